// ==== hdl/sbd_pkg.sv ====
// byte and dual-word store decode/execute: types and constants
// assumes a core pipeline that issues instructions and returns
// register values in the same cycle that the read indices are shown
// What this block does
// - wide imm form P,U,W=110 becomes unprivileged
// - wide imm: base 15 or P=W=0 undefined
// - zero-extend short immediate, P/U/W control addressing
// - wide imm unpredictable: source 13/15, writeback base=source
// - offset address, index select, store low byte, writeback
// - offsets 0-31, 0-4095, 0-255 by encoding
// - short register form: no shift, add, index, no writeback
// - wide register form: base 15 undefined, 13/15 unpredictable
// - wide register form shifts offset left 0-3
// - register form: base plus shifted offset, byte store
// - unprivileged: base plus short immediate, offset only
// - unprivileged: base 15 undefined, source 13/15 unpredictable
// - unprivileged access checked as unprivileged code
// - dual with P=W=0 routed to related encodings
// - dual immediate is short immediate times four
// - dual unpredictable cases: writeback overlap, base 15, 13/15
// - dual stores two words, second at plus four
package sbd_pkg;

	// ****************************************
	// encodings, register numbers, dual address step and ready reset value
	// ****************************************
	localparam logic [4:0]  SBD_T1_IMM_PAT  = 5'h0e;
	localparam logic [6:0]  SBD_T1_REG_PAT  = 7'h2a;
	localparam logic [11:0] SBD_W_IMM12_PAT = 12'hf88;
	localparam logic [11:0] SBD_W_BYTE_PAT  = 12'hf80;
	localparam logic [6:0]  SBD_DUAL_PAT    = 7'h74;
	localparam logic [3:0]  SBD_UNPRIV_PAT  = 4'he;
	localparam logic [5:0]  SBD_REG_ZERO    = 6'h00;
	localparam logic [3:0]  SBD_REG_SP      = 4'hd;
	localparam logic [3:0]  SBD_REG_PC      = 4'hf;
	localparam logic [31:0] SBD_DUAL_STEP   = 32'h0000_0004;
	localparam logic        SBD_READY_RST   = 1'b1;

	// ****************************************
	// enumerations
	// ****************************************
	typedef enum logic [2:0] {
		OP_NONE        = 3'b000,
		OP_BYTE_IMM    = 3'b001,
		OP_BYTE_REG    = 3'b010,
		OP_BYTE_UNPRIV = 3'b011,
		OP_DUAL        = 3'b100
	} sbd_op_t;

	typedef enum logic [2:0] {
		R_OK      = 3'b000,
		R_UNDEF   = 3'b001,
		R_UNPRED  = 3'b010,
		R_FAULT   = 3'b011,
		R_RELATED = 3'b100,
		R_OTHER   = 3'b101
	} sbd_status_t;

	typedef enum logic [1:0] {
		S_IDLE = 2'b00,
		S_READ = 2'b01,
		S_MEM1 = 2'b10,
		S_MEM2 = 2'b11
	} sbd_state_t;

	// ****************************************
	// carriers
	// ****************************************
	typedef struct packed {
		sbd_op_t     op;
		sbd_status_t status;
		logic [3:0]  base_idx;
		logic [3:0]  src_idx;
		logic [3:0]  src2_idx;
		logic [3:0]  off_idx;
		logic [31:0] imm32;
		logic [1:0]  shift;
		logic        index;
		logic        add;
		logic        wback;
		logic        unpriv;
	} sbd_dec_t;

	typedef struct packed {
		logic [3:0] base;
		logic [3:0] src;
		logic [3:0] src2;
		logic [3:0] off;
	} sbd_rf_idx_t;

	typedef struct packed {
		logic [31:0] base;
		logic [31:0] src;
		logic [31:0] src2;
		logic [31:0] off;
	} sbd_rf_val_t;

	typedef struct packed {
		logic        valid;
		logic [31:0] addr;
		logic [31:0] wdata;
		logic        is_byte;
		logic        unpriv;
	} sbd_mem_req_t;

	typedef struct packed {
		logic        done;
		sbd_status_t status;
		logic        wb_en;
		logic [3:0]  wb_reg;
		logic [31:0] wb_val;
	} sbd_result_t;

endpackage : sbd_pkg

// ==== hdl/sbd_store_unit.sv ====
// byte and dual-word store decoder with its address and write sequencer
// assumes rf_val answers rf_idx in the cycle after issue, and that the
// memory side answers a held request with a one-cycle ack or err
`timescale 1ns/100ps

module sbd_store_unit (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// instruction issue
	input  wire logic                  issue_valid,
	input  wire logic                  issue_wide,
	input  wire logic [31:0]           issue_instr,
	output logic                       issue_ready,
	// register file
	output sbd_pkg::sbd_rf_idx_t       rf_idx,
	input  wire sbd_pkg::sbd_rf_val_t  rf_val,
	// memory system
	output sbd_pkg::sbd_mem_req_t      mem_req,
	input  wire logic                  mem_ack,
	input  wire logic                  mem_err,
	// completion and writeback
	output sbd_pkg::sbd_result_t       result
);
	import sbd_pkg::*;

	// ****************************************
	// decode
	// ****************************************
	function automatic logic bad_reg(input logic [3:0] r);
		bad_reg = (r == SBD_REG_SP) || (r == SBD_REG_PC);
	endfunction : bad_reg

	function automatic sbd_dec_t sbd_decode(input logic wide, input logic [31:0] ins);
		sbd_dec_t   d;
		logic [15:0] h1;
		logic [15:0] h2;
		h1 = ins[31:16];
		h2 = ins[15:0];
		d = '0;
		d.op = OP_NONE;
		d.status = R_OTHER;
		if (!wide) begin
			d.base_idx = {1'b0, h2[5:3]};
			d.src_idx  = {1'b0, h2[2:0]};
			if (h2[15:11] == SBD_T1_IMM_PAT) begin
				d.op     = OP_BYTE_IMM;
				d.imm32  = {27'h0, h2[10:6]};
				d.index  = 1'b1;
				d.add    = 1'b1;
				d.status = R_OK;
			end else if (h2[15:9] == SBD_T1_REG_PAT) begin
				d.op     = OP_BYTE_REG;
				d.off_idx = {1'b0, h2[8:6]};
				d.shift  = 2'h0;
				d.index  = 1'b1;
				d.add    = 1'b1;
				d.wback  = 1'b0;
				d.status = R_OK;
			end
		end else begin
			d.base_idx = h1[3:0];
			d.src_idx  = h2[15:12];
			if (h1[15:4] == SBD_W_IMM12_PAT) begin
				d.op     = OP_BYTE_IMM;
				d.imm32  = {20'h0, h2[11:0]};
				d.index  = 1'b1;
				d.add    = 1'b1;
				if (h1[3:0] == SBD_REG_PC)
					d.status = R_UNDEF;
				else if (bad_reg(h2[15:12]))
					d.status = R_UNPRED;
				else
					d.status = R_OK;
			end else if (h1[15:4] == SBD_W_BYTE_PAT && h2[11:8] == SBD_UNPRIV_PAT) begin
				d.op     = OP_BYTE_UNPRIV;
				d.imm32  = {24'h0, h2[7:0]};
				d.index  = 1'b1;
				d.add    = 1'b1;
				d.wback  = 1'b0;
				d.unpriv = 1'b1;
				if (h1[3:0] == SBD_REG_PC)
					d.status = R_UNDEF;
				else if (bad_reg(h2[15:12]))
					d.status = R_UNPRED;
				else
					d.status = R_OK;
			end else if (h1[15:4] == SBD_W_BYTE_PAT && h2[11]) begin
				d.op     = OP_BYTE_IMM;
				d.imm32  = {24'h0, h2[7:0]};
				d.index  = h2[10];
				d.add    = h2[9];
				d.wback  = h2[8];
				if (h1[3:0] == SBD_REG_PC || (!h2[10] && !h2[8]))
					d.status = R_UNDEF;
				else if (bad_reg(h2[15:12]) || (h2[8] && h1[3:0] == h2[15:12]))
					d.status = R_UNPRED;
				else
					d.status = R_OK;
			end else if (h1[15:4] == SBD_W_BYTE_PAT && h2[11:6] == SBD_REG_ZERO) begin
				d.op      = OP_BYTE_REG;
				d.off_idx = h2[3:0];
				d.shift   = h2[5:4];
				d.index   = 1'b1;
				d.add     = 1'b1;
				if (h1[3:0] == SBD_REG_PC)
					d.status = R_UNDEF;
				else if (bad_reg(h2[15:12]) || bad_reg(h2[3:0]))
					d.status = R_UNPRED;
				else
					d.status = R_OK;
			end else if (h1[15:9] == SBD_DUAL_PAT && h1[6] && !h1[4]) begin
				d.op       = OP_DUAL;
				d.src2_idx = h2[11:8];
				d.imm32    = {22'h0, h2[7:0], 2'h0};
				d.index    = h1[8];
				d.add      = h1[7];
				d.wback    = h1[5];
				if (!h1[8] && !h1[5])
					d.status = R_RELATED;
				else if ((h1[5] && (h1[3:0] == h2[15:12] || h1[3:0] == h2[11:8]))
					|| h1[3:0] == SBD_REG_PC || bad_reg(h2[15:12]) || bad_reg(h2[11:8]))
					d.status = R_UNPRED;
				else
					d.status = R_OK;
			end
		end
		if (d.status == R_RELATED || d.status == R_OTHER)
			d.op = OP_NONE;
		sbd_decode = d;
	endfunction : sbd_decode

	sbd_dec_t     dec_c;
	sbd_dec_t     dec_q;
	sbd_state_t   state_q;
	sbd_state_t   state_d;
	logic         ready_q;
	logic         issue_take;
	logic [31:0]  offset_c;
	logic [31:0]  offset_addr_c;
	logic [31:0]  addr_c;
	logic         align_bad_c;
	logic [31:0]  offset_addr_q;
	logic [31:0]  src2_q;
	sbd_mem_req_t mem_q;
	sbd_result_t  res_q;

	assign dec_c      = sbd_decode(issue_wide, issue_instr);
	assign issue_take = issue_valid && ready_q;

	always_ff @(posedge clk) begin
		if (!rstn)
			dec_q <= '0;
		else if (issue_take)
			dec_q <= dec_c;
	end

	// ****************************************
	// address calculation
	// ****************************************
	always_comb begin
		if (dec_q.op == OP_BYTE_REG)
			offset_c = rf_val.off << dec_q.shift;
		else
			offset_c = dec_q.imm32;
		offset_addr_c = dec_q.add ? (rf_val.base + offset_c) : (rf_val.base - offset_c);
		addr_c        = dec_q.index ? offset_addr_c : rf_val.base;
		// dual words must be word aligned; treated as a refused write
		align_bad_c   = (dec_q.op == OP_DUAL) && (addr_c[1:0] != 2'h0);
	end

	// ****************************************
	// sequencer
	// ****************************************
	always_comb begin
		state_d = state_q;
		case (state_q)
			S_IDLE: begin
				if (issue_take)
					state_d = S_READ;
			end
			S_READ: begin
				if (dec_q.status == R_OK && !align_bad_c)
					state_d = S_MEM1;
				else
					state_d = S_IDLE;
			end
			S_MEM1: begin
				if (mem_err)
					state_d = S_IDLE;
				else if (mem_ack)
					state_d = (dec_q.op == OP_DUAL) ? S_MEM2 : S_IDLE;
			end
			S_MEM2: begin
				if (mem_ack || mem_err)
					state_d = S_IDLE;
			end
			default: state_d = S_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rstn)
			state_q <= S_IDLE;
		else
			state_q <= state_d;
	end

	// only one instruction in flight keeps writeback ordering trivial
	always_ff @(posedge clk) begin
		if (!rstn)
			ready_q <= SBD_READY_RST;
		else
			ready_q <= (state_d == S_IDLE);
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			offset_addr_q <= '0;
			src2_q        <= '0;
		end else if (state_q == S_READ) begin
			offset_addr_q <= offset_addr_c;
			src2_q        <= rf_val.src2;
		end
	end

	// ****************************************
	// memory writes
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			mem_q <= '0;
		end else if (state_q == S_READ && state_d == S_MEM1) begin
			mem_q.valid   <= 1'b1;
			mem_q.addr    <= addr_c;
			mem_q.wdata   <= (dec_q.op == OP_DUAL) ? rf_val.src : {24'h0, rf_val.src[7:0]};
			mem_q.is_byte <= (dec_q.op != OP_DUAL);
			mem_q.unpriv  <= dec_q.unpriv;
		end else if (state_q == S_MEM1 && state_d == S_MEM2) begin
			mem_q.addr    <= mem_q.addr + SBD_DUAL_STEP;
			mem_q.wdata   <= src2_q;
		end else if (state_d == S_IDLE) begin
			mem_q.valid   <= 1'b0;
		end
	end

	// ****************************************
	// completion and writeback
	// ****************************************
	always_ff @(posedge clk) begin
		if (!rstn) begin
			res_q <= '0;
		end else if (state_q != S_IDLE && state_d == S_IDLE) begin
			res_q.done   <= 1'b1;
			res_q.wb_reg <= dec_q.base_idx;
			res_q.wb_val <= offset_addr_q;
			if (state_q == S_READ) begin
				res_q.status <= align_bad_c ? R_FAULT : dec_q.status;
				res_q.wb_en  <= 1'b0;
			end else begin
				res_q.status <= mem_err ? R_FAULT : R_OK;
				res_q.wb_en  <= !mem_err && dec_q.wback;
			end
		end else begin
			res_q.done  <= 1'b0;
			res_q.wb_en <= 1'b0;
		end
	end

	assign issue_ready = ready_q;
	assign rf_idx      = '{base: dec_q.base_idx, src: dec_q.src_idx, src2: dec_q.src2_idx, off: dec_q.off_idx};
	assign mem_req     = mem_q;
	assign result      = res_q;

	// ****************************************
	// checks
	// ****************************************
	AST_UNPRIV_ROUTE: assert property (@(posedge clk) disable iff (!rstn)
		(issue_wide && issue_instr[31:20] == SBD_W_BYTE_PAT && issue_instr[11:8] == SBD_UNPRIV_PAT)
		|-> dec_c.op == OP_BYTE_UNPRIV)
		else $error("unprivileged form not recognised");

	AST_UNDEF_DONE: assert property (@(posedge clk) disable iff (!rstn)
		(issue_take && dec_c.status == R_UNDEF)
		|-> ##2 (res_q.done && res_q.status == R_UNDEF && !mem_q.valid))
		else $error("undefined encoding not reported in two cycles");

	AST_BYTE_DATA: assert property (@(posedge clk) disable iff (!rstn)
		(mem_q.valid && dec_q.op != OP_DUAL) |-> (mem_q.is_byte && mem_q.wdata[31:8] == 24'h0))
		else $error("byte store carries more than one byte");

	AST_REG_NO_WB: assert property (@(posedge clk) disable iff (!rstn)
		(res_q.done && dec_q.op == OP_BYTE_REG) |-> !res_q.wb_en)
		else $error("register form wrote back the base");

	AST_UNPRIV_FLAG: assert property (@(posedge clk) disable iff (!rstn)
		mem_q.valid |-> (mem_q.unpriv == (dec_q.op == OP_BYTE_UNPRIV)))
		else $error("unprivileged marking wrong");

	AST_DUAL_IMM: assert property (@(posedge clk) disable iff (!rstn)
		(dec_c.op == OP_DUAL) |-> (dec_c.imm32[1:0] == 2'h0 && dec_c.imm32 <= 32'h0000_03fc))
		else $error("dual immediate not a multiple of four");

	AST_DUAL_SECOND: assert property (@(posedge clk) disable iff (!rstn)
		(state_q == S_MEM1 && dec_q.op == OP_DUAL && mem_ack && !mem_err)
		|=> (mem_q.valid && mem_q.addr == $past(mem_q.addr) + SBD_DUAL_STEP && mem_q.wdata == src2_q))
		else $error("second dual word misplaced");

	AST_FAULT_NO_WB: assert property (@(posedge clk) disable iff (!rstn)
		(state_q != S_IDLE && state_q != S_READ && mem_err)
		|=> (res_q.done && res_q.status == R_FAULT && !res_q.wb_en) ##1 !res_q.done)
		else $error("refused write updated the base");

endmodule : sbd_store_unit

// ==== tb/sbd_mem_model.sv ====
// memory system model on the store port of the byte/dual store unit
// assumes a level request held until a one-cycle ack or err answer
`timescale 1ns/100ps

module sbd_mem_model (
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  rstn,
	// store port
	input  wire sbd_pkg::sbd_mem_req_t mem_req,
	output logic                       mem_ack,
	output logic                       mem_err,
	// bench control and log
	input  wire logic [3:0]            delay,
	input  wire logic [1:0]            fail_n,
	input  wire logic                  log_clr,
	output logic [1:0]                 req_cnt,
	output sbd_pkg::sbd_mem_req_t      log0,
	output sbd_pkg::sbd_mem_req_t      log1
);
	import sbd_pkg::*;

	logic [3:0] wait_q;
	logic       answer;

	// one answer per request; a slow memory waits delay cycles
	assign answer = mem_req.valid && !mem_ack && !mem_err && (wait_q == delay);

	always_ff @(posedge clk) begin
		if (!rstn || !mem_req.valid || mem_ack || mem_err) begin
			wait_q <= 4'h0;
		end else if (wait_q != delay) begin
			wait_q <= wait_q + 4'h1;
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn) begin
			mem_ack <= 1'b0;
			mem_err <= 1'b0;
		end else begin
			mem_ack <= answer && ((req_cnt + 2'h1) != fail_n);
			mem_err <= answer && ((req_cnt + 2'h1) == fail_n);
		end
	end

	always_ff @(posedge clk) begin
		if (!rstn || log_clr) begin
			req_cnt <= 2'h0;
		end else if (answer) begin
			req_cnt <= req_cnt + 2'h1;
			if (req_cnt == 2'h0) begin
				log0 <= mem_req;
			end else begin
				log1 <= mem_req;
			end
		end
	end

endmodule : sbd_mem_model

// ==== tb/sbd_store_unit_test.sv ====
// self-checking bench for the byte and dual-word store unit
// assumes the store unit and the memory model; bench acts as register file
`timescale 1ns/100ps

module sbd_store_unit_test;
	import sbd_pkg::*;

	logic                clk = 1'b0;
	logic                rstn = 1'b0;
	logic                issue_valid = 1'b0;
	logic                issue_wide = 1'b0;
	logic [31:0]         issue_instr = 32'h0;
	logic                issue_ready;
	sbd_rf_idx_t         rf_idx;
	sbd_rf_val_t         rf_val;
	sbd_mem_req_t        mem_req, log0, log1;
	logic                mem_ack, mem_err, log_clr = 1'b0;
	logic [3:0]          delay = 4'h0;
	logic [1:0]          fail_n = 2'h0, req_cnt;
	sbd_result_t         result;
	int                  err_total = 0, total_checks = 0, cyc = 0;

	always #20 clk = ~clk;

	sbd_store_unit dut_u (.clk(clk), .rstn(rstn), .issue_valid(issue_valid), .issue_wide(issue_wide),
		.issue_instr(issue_instr), .issue_ready(issue_ready), .rf_idx(rf_idx), .rf_val(rf_val),
		.mem_req(mem_req), .mem_ack(mem_ack), .mem_err(mem_err), .result(result));
	sbd_mem_model mem_u (.clk(clk), .rstn(rstn), .mem_req(mem_req), .mem_ack(mem_ack), .mem_err(mem_err),
		.delay(delay), .fail_n(fail_n), .log_clr(log_clr), .req_cnt(req_cnt), .log0(log0), .log1(log1));

	// register file: distinct aligned values, low byte differs per register
	function automatic logic [31:0] rv(input logic [3:0] i);
		return {4'h2, i, 16'h0000, i, 4'h0};
	endfunction : rv
	assign rf_val = '{base: rv(rf_idx.base), src: rv(rf_idx.src), src2: rv(rf_idx.src2), off: rv(rf_idx.off)};

	// ****************************************
	// encoders and common checks
	// ****************************************
	function automatic logic [31:0] fi8(input logic [3:0] n, t, input logic p, u, w, input logic [7:0] im);
		return {12'hf80, n, t, 1'b1, p, u, w, im};
	endfunction : fi8
	function automatic logic [31:0] fr(input logic [3:0] n, t, input logic [1:0] sh, input logic [3:0] m);
		return {12'hf80, n, t, 6'h00, sh, m};
	endfunction : fr
	function automatic logic [31:0] fd(input logic p, u, w, input logic [3:0] n, t, t2, input logic [7:0] im);
		return {7'h74, p, u, 1'b1, w, 1'b0, n, t, t2, im};
	endfunction : fd

	task automatic chk(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp) begin
			err_total++;
			$display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask : chk

	task automatic run(input logic w, input logic [31:0] ins, input sbd_status_t st, input int nwr,
		input logic byt, up, input logic [31:0] a0, d0, d1, input logic wb, input logic [3:0] wr,
		input logic [31:0] wbv);
		int n;
		log_clr = 1'b1;
		issue_wide = w;
		issue_instr = ins;
		issue_valid = 1'b1;
		@(posedge clk);
		#1;
		issue_valid = 1'b0;
		log_clr = 1'b0;
		chk(issue_ready, 1'b0);
		n = 0;
		while (result.done !== 1'b1 && n < 40) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk(result.done, 1'b1);
		chk(issue_ready, 1'b1);
		chk(result.status, st);
		chk(result.wb_en, wb);
		if (wb) begin
			chk(result.wb_reg, wr);
			chk(result.wb_val, wbv);
		end
		chk(req_cnt, nwr);
		if (nwr > 0) begin
			chk(log0.addr, a0);
			chk(byt ? {24'h0, log0.wdata[7:0]} : log0.wdata, byt ? {24'h0, d0[7:0]} : d0);
			chk({log0.is_byte, log0.unpriv}, {byt, up});
		end
		if (nwr > 1) begin
			chk(log1.addr, a0 + 32'h4);
			chk({log1.is_byte, log1.wdata}, {1'b0, d1});
		end
	endtask : run

	// ****************************************
	// scenarios
	// ****************************************
	// indexing forms
	task automatic t_short_immediate;
		run(1, fi8(2, 5, 1, 0, 1, 8'hff), R_OK, 1, 1, 0, rv(2) - 255, rv(5), 0, 1, 2, rv(2) - 255);
		run(1, fi8(3, 4, 0, 1, 1, 8'h80), R_OK, 1, 1, 0, rv(3), rv(4), 0, 1, 3, rv(3) + 128);
		run(1, fi8(2, 5, 1, 0, 0, 8'h01), R_OK, 1, 1, 0, rv(2) - 1, rv(5), 0, 0, 0, 0);
	endtask : t_short_immediate

	task automatic t_unpriv;
		run(1, fi8(6, 7, 1, 1, 0, 8'hff), R_OK, 1, 1, 1, rv(6) + 255, rv(7), 0, 0, 0, 0);
	endtask : t_unpriv

	task automatic t_undef;
		run(1, fi8(15, 4, 1, 0, 1, 8'h04), R_UNDEF, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fi8(3, 4, 0, 1, 0, 8'h04), R_UNDEF, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fr(15, 4, 2'h1, 5), R_UNDEF, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fi8(15, 4, 1, 1, 0, 8'h04), R_UNDEF, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, {12'hf88, 4'hf, 4'h2, 12'h001}, R_UNDEF, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		// not one of these stores: no memory touched
		run(0, 32'h0, R_OTHER, 0, 0, 0, 0, 0, 0, 0, 0, 0);
	endtask : t_undef

	task automatic t_unpred;
		run(1, fi8(2, 13, 1, 0, 1, 8'h04), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fi8(2, 15, 1, 0, 0, 8'h04), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fi8(4, 4, 1, 1, 1, 8'h04), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fr(2, 13, 2'h0, 5), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fr(2, 3, 2'h0, 15), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fi8(2, 15, 1, 1, 0, 8'h04), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, {12'hf88, 4'h2, 4'hd, 12'h001}, R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fd(1, 1, 1, 4, 3, 4, 8'h01), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fd(1, 1, 0, 15, 3, 4, 8'h01), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fd(1, 1, 0, 2, 13, 4, 8'h01), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		run(1, fd(1, 1, 0, 2, 3, 15, 8'h01), R_UNPRED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
	endtask : t_unpred

	task automatic t_reg;
		run(0, {16'h0, 7'h2a, 3'h3, 3'h1, 3'h2}, R_OK, 1, 1, 0, rv(1) + rv(3), rv(2), 0, 0, 0, 0);
		for (int s = 0; s < 4; s++) begin
			run(1, fr(8, 10, s[1:0], 9), R_OK, 1, 1, 0, rv(8) + (rv(9) << s), rv(10), 0, 0, 0, 0);
		end
		run(0, {16'h0, 5'h0e, 5'h1f, 3'h1, 3'h2}, R_OK, 1, 1, 0, rv(1) + 31, rv(2), 0, 0, 0, 0);
		run(1, {12'hf88, 4'hb, 4'hc, 12'hfff}, R_OK, 1, 1, 0, rv(11) + 4095, rv(12), 0, 0, 0, 0);
	endtask : t_reg

	task automatic t_dual;
		delay = 4'h3;
		run(1, fd(1, 1, 1, 2, 3, 4, 8'hff), R_OK, 2, 0, 0, rv(2) + 1020, rv(3), rv(4), 1, 2, rv(2) + 1020);
		run(1, fd(0, 0, 1, 5, 6, 7, 8'h01), R_OK, 2, 0, 0, rv(5), rv(6), rv(7), 1, 5, rv(5) - 4);
		run(1, fd(0, 1, 0, 5, 6, 7, 8'h01), R_RELATED, 0, 0, 0, 0, 0, 0, 0, 0, 0);
		delay = 4'h0;
	endtask : t_dual

	// refused writes, byte store first request and dual second word
	// a refused write is still one answered request in the log
	task automatic t_fault;
		fail_n = 2'h1;
		run(1, fi8(2, 5, 1, 0, 1, 8'h10), R_FAULT, 1, 1, 0, rv(2) - 16, rv(5), 0, 0, 0, 0);
		fail_n = 2'h2;
		run(1, fd(1, 1, 1, 2, 3, 4, 8'h02), R_FAULT, 2, 0, 0, rv(2) + 8, rv(3), rv(4), 0, 0, 0);
		fail_n = 2'h0;
	endtask : t_fault

	// ****************************************
	// sequence, hang guard and verdict
	// ****************************************
	task automatic conclude;
		if (err_total == 0 && total_checks > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask : conclude

	// whole run needs well under a thousand cycles
	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			err_total++;
			conclude();
		end
	end

	initial begin
		repeat (2) @(posedge clk);
		#1;
		rstn = 1'b1;
		@(posedge clk);
		#1;
		t_short_immediate();
		t_unpriv();
		t_undef();
		t_unpred();
		t_reg();
		t_dual();
		t_fault();
		conclude();
	end

endmodule : sbd_store_unit_test
